// >>> design/amrr_regs.sv
// Module: APB register bank for analog mixer routing, mute and level controls
`default_nettype none
module amrr_regs
  import amrr_pkg::*;
(
  input  wire  logic        SYS_CLK,
  input  wire  logic        NRST,
  input  wire  logic        PSEL,
  input  wire  logic        PENABLE,
  input  wire  logic        PWRITE,
  input  wire  logic [7:0]  PADDR,
  input  wire  logic [31:0] PWDATA,
  input  wire  logic [3:0]  PSTRB,
  output logic        [31:0] PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  input  wire  logic        POWER_DOWN_PIN_N,
  output logic        [3:0] LINEOUT_VOLUME_CODE,
  output logic              LINEOUT_SILENCE,
  output logic        [7:0] HP_ROUTING,
  output logic        [4:0] HEADPHONE_ATTEN_CODE,
  output logic              HEADPHONE_SILENCE,
  output logic              HEADPHONE_WEAK_PULLDOWN,
  output logic        [7:0] LINE_ROUTING,
  output logic        [2:0] PAIR_AVG_TO_HEADPHONE,
  output logic        [2:0] PAIR_AVG_TO_LINEOUT,
  output logic              DIFF_INPUT_ENABLE,
  output logic              DIFF_TO_LINEOUT,
  output logic              DIFF_TO_HEADPHONE,
  output logic              DIFF_TO_MONO,
  output logic              INPUT_ONE_AS_DIFF,
  output logic        [7:0] MONO_ROUTING,
  output logic        [3:0] MONO_ATTEN_CODE,
  output logic              MONO_SILENCE,
  output logic              MONO_DAC_GAIN_SEL,
  output logic              MONO_OUTPUT_POWER,
  output logic              MONO_OUTPUT_PIN_HIZ
);

  // ==========================================================================
  // Pin synchroniser for the power-down pin
  logic pdn_meta_q;   // First stage, read only by second stage
  logic pdn_sync_q;   // Second stage, safe to use
  logic restore;      // Power-down active

  // Two-flop crossing; pin is asynchronous to SYS_CLK
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pdn_meta_q <= 1'b0;
      pdn_sync_q <= 1'b0;
    end
    else
    begin
      pdn_meta_q <= POWER_DOWN_PIN_N;
      pdn_sync_q <= pdn_meta_q;
    end
  end

  assign restore = !pdn_sync_q;

  // ==========================================================================
  // Address decode
  // Index = byte address / 4; misaligned or unknown addresses error
  function automatic logic [NUM_REGS-1:0] decode(input logic [7:0] addr);
    logic [NUM_REGS-1:0] hit;
    hit = '0;
    if (addr[1:0] == 2'b00)
    begin
      unique case ({2'b00, addr[7:2]})
        IDX_LINEOUT_CTRL:  hit[0] = 1'b1;
        IDX_LINEOUT_ATTEN: hit[1] = 1'b1;
        IDX_HP_ROUTING:    hit[2] = 1'b1;
        IDX_HP_LEVEL:      hit[3] = 1'b1;
        IDX_LINE_ROUTING:  hit[4] = 1'b1;
        IDX_PAIR_AVERAGE:  hit[5] = 1'b1;
        IDX_DIFF_ROUTING:  hit[6] = 1'b1;
        IDX_MONO_ROUTING:  hit[7] = 1'b1;
        IDX_MONO_LEVEL:    hit[8] = 1'b1;
        default:           hit = '0;
      endcase
    end
    return hit;
  endfunction : decode

  logic [NUM_REGS-1:0] sel;        // One-hot register select
  logic                access;     // Access phase of a transfer
  logic                wr_any;     // Accepted write, low lane enabled
  logic [7:0]          regv [NUM_REGS]; // Register contents

  assign sel    = decode(PADDR);
  assign access = PSEL && PENABLE;
  // Only byte lane 0 holds data; writes ignored during power-down
  assign wr_any = access && PWRITE && PSTRB[0] && !restore;

  // Zero wait states: answer in the first access cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = access && (sel == '0);

  // ==========================================================================
  // Register cells
  localparam logic [7:0] RST_TAB  [NUM_REGS] = '{RST_LINEOUT_CTRL, RST_LINEOUT_ATTEN, RST_ZERO,
                                                 RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
                                                 RST_ZERO, RST_MONO_LEVEL};
  localparam logic [7:0] MASK_TAB [NUM_REGS] = '{MASK_LINEOUT_CTRL, MASK_LINEOUT_ATTEN, MASK_FULL,
                                                 MASK_HP_LEVEL, MASK_FULL, MASK_PAIR_AVERAGE,
                                                 MASK_DIFF_ROUTING, MASK_FULL, MASK_MONO_LEVEL};

  // Each cell keeps defaults through reset and power-down
  for (genvar i = 0; i < NUM_REGS; i++)
  begin : g_cell
    amrr_reg_cell #(
      .RESET_VALUE (RST_TAB[i]),
      .WRITE_MASK  (MASK_TAB[i])
    ) u_cell (
      .clk     (SYS_CLK),
      .rst_n   (NRST),
      .restore (restore),
      .wr_en   (wr_any && sel[i]),
      .wr_data (PWDATA[7:0]),
      .value   (regv[i])
    );
  end

  // ==========================================================================
  // Read data register; upper bits always zero
  logic [31:0] prdata_q; // Captured read data
  logic [7:0]  rd_mux;   // Selected register

  always_comb
  begin
    rd_mux = 8'h00;
    for (int k = 0; k < NUM_REGS; k++)
    begin
      if (sel[k])
      begin
        rd_mux = rd_mux | regv[k];
      end
    end
  end

  // Data is launched in setup so it stands valid in the access cycle
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (PSEL && !PENABLE && !PWRITE)
    begin
      prdata_q <= {24'h00_0000, rd_mux};
    end
  end

  assign PRDATA = prdata_q;

  // ==========================================================================
  // Effective controls from register flops
  logic [7:0] lo_ctrl;  // Lineout silence register
  logic [7:0] lo_att;   // Lineout volume register
  logic [7:0] hp_lvl;   // Headphone level register
  logic [7:0] pavg;     // Pair average register
  logic [7:0] diff;     // Differential routing register
  logic [7:0] mlvl;     // Mono level register

  assign lo_ctrl = regv[0];
  assign lo_att  = regv[1];
  assign hp_lvl  = regv[3];
  assign pavg    = regv[5];
  assign diff    = regv[6];
  assign mlvl    = regv[8];

  assign LINEOUT_SILENCE = lo_ctrl[LINEOUT_SILENCE_POS];
  // Muted path forces the volume code to zero so the analog side sees silence
  assign LINEOUT_VOLUME_CODE = LINEOUT_SILENCE ? 4'h0 : lo_att[3:0];

  assign HP_ROUTING = regv[2];
  assign HEADPHONE_SILENCE = hp_lvl[HP_SILENCE_POS];
  assign HEADPHONE_ATTEN_CODE = HEADPHONE_SILENCE ? 5'h00 : hp_lvl[4:0];
  assign HEADPHONE_WEAK_PULLDOWN = hp_lvl[HP_PULLDOWN_POS];

  assign LINE_ROUTING = regv[4];
  // Even bits feed the headphone average, odd bits the lineout
  assign PAIR_AVG_TO_HEADPHONE = {pavg[4], pavg[2], pavg[0]};
  assign PAIR_AVG_TO_LINEOUT   = {pavg[5], pavg[3], pavg[1]};

  assign DIFF_INPUT_ENABLE = diff[DIFF_ENABLE_POS];
  assign DIFF_TO_LINEOUT   = DIFF_INPUT_ENABLE;
  assign INPUT_ONE_AS_DIFF = DIFF_INPUT_ENABLE;
  assign DIFF_TO_HEADPHONE = DIFF_INPUT_ENABLE && diff[DIFF_TO_HP_POS];
  assign DIFF_TO_MONO      = DIFF_INPUT_ENABLE && diff[DIFF_TO_MONO_POS];

  assign MONO_ROUTING = regv[7];
  assign MONO_SILENCE = mlvl[MONO_SILENCE_POS];
  assign MONO_ATTEN_CODE = MONO_SILENCE ? 4'h0 : mlvl[3:0];
  assign MONO_DAC_GAIN_SEL = mlvl[MONO_GAIN_POS];
  assign MONO_OUTPUT_POWER = mlvl[MONO_POWER_POS] && !restore;
  assign MONO_OUTPUT_PIN_HIZ = !MONO_OUTPUT_POWER;

endmodule : amrr_regs
`default_nettype wire

// >>> include/amrr_pkg.sv
// Package: offsets, field positions and reset values of the analog route registers
`default_nettype none
package amrr_pkg;

  // ==========================================================================
  // Register indices; the bus byte address is the index times four, since registers are word aligned
  localparam logic [7:0] ADDR_BITS          = 8'h08;
  localparam logic [7:0] IDX_LINEOUT_ATTEN  = 8'h09;
  localparam logic [7:0] IDX_LINEOUT_CTRL   = 8'h04;
  localparam logic [7:0] IDX_HP_ROUTING     = 8'h0D;
  localparam logic [7:0] IDX_HP_LEVEL       = 8'h0E;
  localparam logic [7:0] IDX_LINE_ROUTING   = 8'h0F;
  localparam logic [7:0] IDX_PAIR_AVERAGE   = 8'h10;
  localparam logic [7:0] IDX_DIFF_ROUTING   = 8'h11;
  localparam logic [7:0] IDX_MONO_ROUTING   = 8'h12;
  localparam logic [7:0] IDX_MONO_LEVEL     = 8'h13;

  // ==========================================================================
  // Writable masks; zero bits are fixed zero positions
  localparam logic [7:0] MASK_LINEOUT_ATTEN = 8'h0F;
  localparam logic [7:0] MASK_LINEOUT_CTRL  = 8'h20;
  localparam logic [7:0] MASK_FULL          = 8'hFF;
  localparam logic [7:0] MASK_HP_LEVEL      = 8'h7F;
  localparam logic [7:0] MASK_PAIR_AVERAGE  = 8'h3F;
  localparam logic [7:0] MASK_DIFF_ROUTING  = 8'h07;
  localparam logic [7:0] MASK_MONO_LEVEL    = 8'h7F;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_LINEOUT_ATTEN  = 8'h00;
  localparam logic [7:0] RST_LINEOUT_CTRL   = 8'h20;
  localparam logic [7:0] RST_ZERO           = 8'h00;
  localparam logic [7:0] RST_MONO_LEVEL     = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int LINEOUT_SILENCE_POS   = 5;
  localparam int HP_SILENCE_POS        = 5;
  localparam int HP_PULLDOWN_POS       = 6;
  localparam int DIFF_ENABLE_POS       = 0;
  localparam int DIFF_TO_HP_POS        = 1;
  localparam int DIFF_TO_MONO_POS      = 2;
  localparam int MONO_SILENCE_POS      = 4;
  localparam int MONO_GAIN_POS         = 5;
  localparam int MONO_POWER_POS        = 6;

  // Register bank size
  localparam int NUM_REGS              = 9;

endpackage : amrr_pkg
`default_nettype wire

// >>> design/amrr_reg_cell.sv
// Module: one 8-bit register cell with write mask and power-down restore
`default_nettype none
module amrr_reg_cell
  import amrr_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK  = 8'hFF
)
(
  input  wire  logic       clk,
  input  wire  logic       rst_n,
  input  wire  logic       restore,
  input  wire  logic       wr_en,
  input  wire  logic [7:0] wr_data,
  output logic       [7:0] value
);

  // ==========================================================================
  // Storage
  logic [7:0] value_q; // Held contents

  // Write merges only maskable bits; fixed bits stay zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value_q <= RESET_VALUE;
    end
    else if (restore)
    begin
      // Power-down pin restores default every cycle it is low
      value_q <= RESET_VALUE;
    end
    else if (wr_en)
    begin
      value_q <= wr_data & WRITE_MASK;
    end
  end

  assign value = value_q;

endmodule : amrr_reg_cell
`default_nettype wire

// >>> verification/amrr_regs_asserts.sv
// Checker: timing relations of the analog route register bank
`default_nettype none
module amrr_regs_chk
(
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic        POWER_DOWN_PIN_N,
  input wire logic [3:0]  LINEOUT_VOLUME_CODE,
  input wire logic        LINEOUT_SILENCE,
  input wire logic [7:0]  HP_ROUTING,
  input wire logic [4:0]  HEADPHONE_ATTEN_CODE,
  input wire logic        HEADPHONE_SILENCE,
  input wire logic        DIFF_INPUT_ENABLE,
  input wire logic        DIFF_TO_HEADPHONE,
  input wire logic        DIFF_TO_MONO,
  input wire logic [3:0]  MONO_ATTEN_CODE,
  input wire logic        MONO_SILENCE,
  input wire logic        MONO_OUTPUT_POWER,
  input wire logic        MONO_OUTPUT_PIN_HIZ
);
  // ==========================================
  // Single domain, so clock and reset are set once
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // Four low samples: two for the synchroniser, margin for the restore
  sequence s_pdn; !POWER_DOWN_PIN_N [*4]; endsequence
  // Accepted writes; byte address 0x34 is headphone routing, 0x10 lineout control
  sequence s_hp_wr; PSEL && PENABLE && PWRITE && PSTRB[0] && POWER_DOWN_PIN_N && PADDR == 8'h34; endsequence
  sequence s_lo_wr; PSEL && PENABLE && PWRITE && PSTRB[0] && POWER_DOWN_PIN_N && PADDR == 8'h10; endsequence
  // ==========================================
  // Properties
  property p_lo_mute; LINEOUT_SILENCE |-> LINEOUT_VOLUME_CODE == 4'h0; endproperty
  a_lo_mute: assert property (p_lo_mute) else $error("lineout volume passed while silenced");
  property p_hp_mute; HEADPHONE_SILENCE |-> HEADPHONE_ATTEN_CODE == 5'h00; endproperty
  a_hp_mute: assert property (p_hp_mute) else $error("headphone code passed while silenced");
  property p_mono_mute; MONO_SILENCE |-> MONO_ATTEN_CODE == 4'h0; endproperty
  a_mono_mute: assert property (p_mono_mute) else $error("mono code passed while silenced");
  property p_diff_hp; DIFF_TO_HEADPHONE |-> DIFF_INPUT_ENABLE; endproperty
  a_diff_hp: assert property (p_diff_hp) else $error("diff to headphone without enable");
  property p_diff_mono; DIFF_TO_MONO |-> DIFF_INPUT_ENABLE; endproperty
  a_diff_mono: assert property (p_diff_mono) else $error("diff to mono without enable");
  property p_hiz; MONO_OUTPUT_PIN_HIZ != MONO_OUTPUT_POWER; endproperty
  a_hiz: assert property (p_hiz) else $error("mono pin drive and power disagree");
  property p_pdn; s_pdn |-> LINEOUT_SILENCE && MONO_SILENCE && HP_ROUTING == 8'h00 && !MONO_OUTPUT_POWER; endproperty
  a_pdn: assert property (p_pdn) else $error("defaults not held in power-down");
  property p_hp_wr; s_hp_wr |=> HP_ROUTING == $past(PWDATA[7:0]); endproperty
  a_hp_wr: assert property (p_hp_wr) else $error("headphone routing write lost");
  property p_lo_wr; s_lo_wr |=> LINEOUT_SILENCE == $past(PWDATA[5]); endproperty
  a_lo_wr: assert property (p_lo_wr) else $error("lineout silence write lost");
endmodule : amrr_regs_chk

bind amrr_regs amrr_regs_chk amrr_regs_chk_inst (.*);
`default_nettype wire

// >>> verification/tb_amrr_regs.sv
// Testbench: APB register bank for analog mixer routing
`default_nettype none
module tb_amrr_regs
  import amrr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Ports of the block
  logic        SYS_CLK = 1'b0;
  logic        NRST = 1'b0;
  logic        POWER_DOWN_PIN_N = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [3:0]  PSTRB = 4'h0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, LINEOUT_SILENCE, HEADPHONE_SILENCE, HEADPHONE_WEAK_PULLDOWN, MONO_SILENCE;
  logic        DIFF_INPUT_ENABLE, DIFF_TO_LINEOUT, DIFF_TO_HEADPHONE, DIFF_TO_MONO, INPUT_ONE_AS_DIFF;
  logic        MONO_DAC_GAIN_SEL, MONO_OUTPUT_POWER, MONO_OUTPUT_PIN_HIZ;
  logic [3:0]  LINEOUT_VOLUME_CODE, MONO_ATTEN_CODE;
  logic [4:0]  HEADPHONE_ATTEN_CODE;
  logic [2:0]  PAIR_AVG_TO_HEADPHONE, PAIR_AVG_TO_LINEOUT;
  logic [7:0]  HP_ROUTING, LINE_ROUTING, MONO_ROUTING;
  // Register table: index, writable mask, reset value, expected content
  logic [7:0]  ix [9] = '{IDX_LINEOUT_CTRL, IDX_LINEOUT_ATTEN, IDX_HP_ROUTING, IDX_HP_LEVEL, IDX_LINE_ROUTING,
                          IDX_PAIR_AVERAGE, IDX_DIFF_ROUTING, IDX_MONO_ROUTING, IDX_MONO_LEVEL};
  logic [7:0]  mk [9] = '{MASK_LINEOUT_CTRL, MASK_LINEOUT_ATTEN, MASK_FULL, MASK_HP_LEVEL, MASK_FULL,
                          MASK_PAIR_AVERAGE, MASK_DIFF_ROUTING, MASK_FULL, MASK_MONO_LEVEL};
  logic [7:0]  rs [9] = '{RST_LINEOUT_CTRL, RST_LINEOUT_ATTEN, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
                          RST_ZERO, RST_ZERO, RST_MONO_LEVEL};
  logic [7:0]  m [9];
  logic [32:0] expq [$];
  int          error_cnt = 0;
  int          checks_done = 0;

  amrr_regs amrr_regs_inst (.*);

  always #12.5 SYS_CLK = ~SYS_CLK;

  // ==========================================
  // Shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // One APB transfer; a read notes its expected {error, data}
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                     input logic [32:0] e);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h00_0000, d};
    PSTRB <= s;
    if (!wr)
      expq.push_back(e);
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask : apb

  task automatic wr(input int i, input logic [7:0] d);
    apb(1'b1, {ix[i][5:0], 2'b00}, d, 4'hF, '0);
    m[i] = d & mk[i];
  endtask : wr

  task automatic rdall();
    for (int i = 0; i < 9; i++)
      apb(1'b0, {ix[i][5:0], 2'b00}, 8'h00, 4'h0, {25'h000_0000, m[i]});
  endtask : rdall

  // Sampled mid-cycle so the last edge's updates have landed
  task automatic ports();
    @(negedge SYS_CLK);
    check({HP_ROUTING, LINE_ROUTING, MONO_ROUTING, LINEOUT_SILENCE, LINEOUT_VOLUME_CODE, HEADPHONE_SILENCE,
           HEADPHONE_ATTEN_CODE, HEADPHONE_WEAK_PULLDOWN, PAIR_AVG_TO_HEADPHONE, PAIR_AVG_TO_LINEOUT,
           DIFF_INPUT_ENABLE, DIFF_TO_LINEOUT, DIFF_TO_HEADPHONE, DIFF_TO_MONO, INPUT_ONE_AS_DIFF, MONO_SILENCE,
           MONO_ATTEN_CODE, MONO_DAC_GAIN_SEL, MONO_OUTPUT_POWER, MONO_OUTPUT_PIN_HIZ},
          {m[2], m[4], m[7], m[0][5], m[0][5] ? 4'h0 : m[1][3:0], m[3][5], m[3][5] ? 5'h00 : m[3][4:0],
           m[3][6], m[5][4], m[5][2], m[5][0], m[5][5], m[5][3], m[5][1], m[6][0], m[6][0], m[6][0] & m[6][1],
           m[6][0] & m[6][2], m[6][0], m[8][4], m[8][4] ? 4'h0 : m[8][3:0], m[8][5], m[8][6],
           !m[8][6]});
    @(posedge SYS_CLK);
  endtask : ports

  // Read monitor: oldest note against what the access phase returns
  always @(posedge SYS_CLK)
    if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1)
      check({PSLVERR, PRDATA}, expq.pop_front());
    else if (PSEL && PENABLE && PWRITE && PREADY === 1'b1)
      check(PSLVERR, 1'b0);

  // ==========================================
  // Test sequence
  initial
  begin
    void'($urandom(22));
    repeat (10) @(posedge SYS_CLK);
    NRST <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    m = rs;
    rdall();
    ports();
    $display("reset defaults test done");
    repeat (12)
    begin
      for (int i = 0; i < 9; i++)
        wr(i, 8'($urandom));
      rdall();
      ports();
    end
    $display("random field test done");
    // Lane 0 off must change nothing; unmapped and misaligned reads must return an error
    apb(1'b1, 8'h34, ~m[2], 4'hE, '0);
    apb(1'b0, 8'h00, 8'h00, 4'h0, {1'b1, 32'h0000_0000});
    apb(1'b0, 8'h35, 8'h00, 4'h0, {1'b1, 32'h0000_0000});
    rdall();
    $display("refused access test done");
    // Power-down: a write inside it is dropped, defaults come back
    POWER_DOWN_PIN_N <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    apb(1'b1, 8'h34, 8'hA5, 4'hF, '0);
    POWER_DOWN_PIN_N <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    m = rs;
    rdall();
    ports();
    $display("power-down restore test done");
    give_verdict();
  end

  // Watchdog, about five times the expected run
  initial
  begin
    #100_000;
    error_cnt++;
    give_verdict();
  end
endmodule : tb_amrr_regs
`default_nettype wire
